//--- bstap_core.sv
// Boundary-scan port controller with instruction and data registers
`timescale 1ns/1ns
module bstap_core (
    // System clock domain
    input wire logic clock,
    input wire logic srst,
    // Scan link, clocked by the link's own clock
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOeN,
    // Pin levels captured into boundary cells
    input wire logic [39:0] pinSample,
    // Scan-domain results
    output bstap_pkg::bstap_ctl_t ctl,
    output logic [7:0] instruction,
    output logic [39:0] bsrUpdate,
    output logic [10:0] boundary_control_register,
    output logic runTest,
    // System-domain status
    output logic sysTestMode,
    output logic sysTapReset
);
    // Reset crossing into the scan domain
    logic rstMeta_ff;
    logic rstSync_ff;
    // Controller state
    bstap_pkg::bstap_state_t state_ff;
    bstap_pkg::bstap_state_t nxt_state;
    // Shift stages
    logic [7:0] irShift_ff;
    logic [39:0] bsrShift_ff;
    logic [10:0] ctrlShift_ff;
    logic bypass_ff;
    // Pin sampling synchroniser
    logic [39:0] pinMeta_ff;
    logic [39:0] pinSync_ff;
    // Shadow latches
    logic [7:0] instr_ff;
    logic [39:0] bsrShadow_ff;
    logic [10:0] ctrlShadow_ff;
    logic tdo_ff;
    logic tdoOeN_ff;
    logic runTest_ff;
    // System-side synchronisers
    logic modeMeta_ff;
    logic modeSync_ff;
    logic rstStMeta_ff;
    logic rstStSync_ff;
    logic inReset_ff;
    // Decoded instruction
    bstap_pkg::bstap_ctl_t dec;

    // Instruction decode; bad parity or unknown opcode falls back to bypass
    always_comb begin
        dec = '0;
        if (^instr_ff == 1'b0) begin
            unique case (instr_ff)
                bstap_pkg::OP_EXTEST, bstap_pkg::OP_INTEST: begin
                    dec.testMode = 1'b1;
                    dec.selBsr = 1'b1;
                    dec.capturePins = 1'b1;
                end
                bstap_pkg::OP_SAMPLE: begin
                    dec.selBsr = 1'b1;
                    dec.capturePins = 1'b1;
                end
                bstap_pkg::OP_HIGHZ: begin
                    dec.testMode = 1'b1;
                    dec.highZ = 1'b1;
                end
                bstap_pkg::OP_RUN_CTRL: begin
                    dec.selCtrl = 1'b1;
                end
                default: begin
                    dec = '0;
                end
            endcase
        end
    end

    // Srst is a system-clock level; two flops before the scan logic reads it
    always_ff @(posedge tck) begin
        rstMeta_ff <= srst;
        rstSync_ff <= rstMeta_ff;
    end

    // Pins are asynchronous to the scan clock
    always_ff @(posedge tck) begin
        pinMeta_ff <= pinSample;
        pinSync_ff <= pinMeta_ff;
    end

    // Next-state table, TMS sampled at rising edge
    always_comb begin
        unique case (state_ff)
            bstap_pkg::TEST_RESET: nxt_state = tms ? bstap_pkg::TEST_RESET : bstap_pkg::RUN_IDLE;
            bstap_pkg::RUN_IDLE: nxt_state = tms ? bstap_pkg::SEL_DR : bstap_pkg::RUN_IDLE;
            bstap_pkg::SEL_DR: nxt_state = tms ? bstap_pkg::SEL_IR : bstap_pkg::CAP_DR;
            bstap_pkg::CAP_DR: nxt_state = tms ? bstap_pkg::EXIT1_DR : bstap_pkg::SHIFT_DR;
            bstap_pkg::SHIFT_DR: nxt_state = tms ? bstap_pkg::EXIT1_DR : bstap_pkg::SHIFT_DR;
            bstap_pkg::EXIT1_DR: nxt_state = tms ? bstap_pkg::UPD_DR : bstap_pkg::PAUSE_DR;
            bstap_pkg::PAUSE_DR: nxt_state = tms ? bstap_pkg::EXIT2_DR : bstap_pkg::PAUSE_DR;
            bstap_pkg::EXIT2_DR: nxt_state = tms ? bstap_pkg::UPD_DR : bstap_pkg::SHIFT_DR;
            bstap_pkg::UPD_DR: nxt_state = tms ? bstap_pkg::SEL_DR : bstap_pkg::RUN_IDLE;
            bstap_pkg::SEL_IR: nxt_state = tms ? bstap_pkg::TEST_RESET : bstap_pkg::CAP_IR;
            bstap_pkg::CAP_IR: nxt_state = tms ? bstap_pkg::EXIT1_IR : bstap_pkg::SHIFT_IR;
            bstap_pkg::SHIFT_IR: nxt_state = tms ? bstap_pkg::EXIT1_IR : bstap_pkg::SHIFT_IR;
            bstap_pkg::EXIT1_IR: nxt_state = tms ? bstap_pkg::UPD_IR : bstap_pkg::PAUSE_IR;
            bstap_pkg::PAUSE_IR: nxt_state = tms ? bstap_pkg::EXIT2_IR : bstap_pkg::PAUSE_IR;
            bstap_pkg::EXIT2_IR: nxt_state = tms ? bstap_pkg::UPD_IR : bstap_pkg::SHIFT_IR;
            bstap_pkg::UPD_IR: nxt_state = tms ? bstap_pkg::SEL_DR : bstap_pkg::RUN_IDLE;
        endcase
    end

    // State register; power-up reset forces the reset state
    always_ff @(posedge tck) begin
        if (rstSync_ff) begin
            state_ff <= bstap_pkg::TEST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Instruction shift stage
    always_ff @(posedge tck) begin
        if (rstSync_ff || state_ff == bstap_pkg::TEST_RESET) begin
            irShift_ff <= bstap_pkg::IR_RESET;
        end else if (state_ff == bstap_pkg::CAP_IR) begin
            irShift_ff <= bstap_pkg::IR_CAPTURE;
        end else if (state_ff == bstap_pkg::SHIFT_IR) begin
            irShift_ff <= {tdi, irShift_ff[7:1]};
        end
    end

    // Boundary shift stage; pause and exit simply hold
    always_ff @(posedge tck) begin
        if (rstSync_ff || state_ff == bstap_pkg::TEST_RESET) begin
            bsrShift_ff <= bstap_pkg::BSR_RESET;
        end else if (state_ff == bstap_pkg::CAP_DR && dec.selBsr && dec.capturePins) begin
            bsrShift_ff <= pinSync_ff;
        end else if (state_ff == bstap_pkg::SHIFT_DR && dec.selBsr) begin
            bsrShift_ff <= {tdi, bsrShift_ff[39:1]};
        end
    end

    // Control shift stage; capture leaves it unchanged
    always_ff @(posedge tck) begin
        if (rstSync_ff || state_ff == bstap_pkg::TEST_RESET) begin
            ctrlShift_ff <= bstap_pkg::CTRL_RESET;
        end else if (state_ff == bstap_pkg::SHIFT_DR && dec.selCtrl) begin
            ctrlShift_ff <= {tdi, ctrlShift_ff[10:1]};
        end
    end

    // Bypass stage, no shadow latch
    always_ff @(posedge tck) begin
        if (rstSync_ff) begin
            bypass_ff <= 1'b0;
        end else if (state_ff == bstap_pkg::CAP_DR && !dec.selBsr && !dec.selCtrl) begin
            bypass_ff <= 1'b0;
        end else if (state_ff == bstap_pkg::SHIFT_DR && !dec.selBsr && !dec.selCtrl) begin
            bypass_ff <= tdi;
        end
    end

    // Run strobe for control-register operations, only in run-idle
    always_ff @(posedge tck) begin
        if (rstSync_ff) begin
            runTest_ff <= 1'b0;
        end else begin
            runTest_ff <= (nxt_state == bstap_pkg::RUN_IDLE) && dec.selCtrl;
        end
    end

    // Instruction shadow, falling edge after entering update
    always_ff @(negedge tck) begin
        if (rstSync_ff || state_ff == bstap_pkg::TEST_RESET) begin
            instr_ff <= bstap_pkg::IR_RESET;
        end else if (state_ff == bstap_pkg::UPD_IR) begin
            instr_ff <= irShift_ff;
        end
    end

    // Data shadows, falling edge after entering update
    always_ff @(negedge tck) begin
        if (rstSync_ff || state_ff == bstap_pkg::TEST_RESET) begin
            bsrShadow_ff <= bstap_pkg::BSR_RESET;
            ctrlShadow_ff <= bstap_pkg::CTRL_RESET;
        end else if (state_ff == bstap_pkg::UPD_DR) begin
            if (dec.selBsr) begin
                bsrShadow_ff <= bsrShift_ff;
            end
            if (dec.selCtrl) begin
                ctrlShadow_ff <= ctrlShift_ff;
            end
        end
    end

    // TDO changes only on the falling edge; enable low while driving
    always_ff @(negedge tck) begin
        if (rstSync_ff) begin
            tdo_ff <= 1'b0;
            tdoOeN_ff <= 1'b1;
        end else if (state_ff == bstap_pkg::SHIFT_IR) begin
            tdo_ff <= irShift_ff[0];
            tdoOeN_ff <= 1'b0;
        end else if (state_ff == bstap_pkg::SHIFT_DR) begin
            tdo_ff <= dec.selBsr ? bsrShift_ff[0] : (dec.selCtrl ? ctrlShift_ff[0] : bypass_ff);
            tdoOeN_ff <= 1'b0;
        end else begin
            tdoOeN_ff <= 1'b1;
        end
    end

    // Reset state registered for crossing; test mode crosses from the ctl flop below
    always_ff @(posedge tck) begin
        if (rstSync_ff) begin
            inReset_ff <= 1'b1;
        end else begin
            inReset_ff <= (nxt_state == bstap_pkg::TEST_RESET);
        end
    end

    // Level crossings into the system domain
    always_ff @(posedge clock) begin
        if (srst) begin
            modeMeta_ff <= 1'b0;
            modeSync_ff <= 1'b0;
            rstStMeta_ff <= 1'b1;
            rstStSync_ff <= 1'b1;
        end else begin
            modeMeta_ff <= ctl.testMode;
            modeSync_ff <= modeMeta_ff;
            rstStMeta_ff <= inReset_ff;
            rstStSync_ff <= rstStMeta_ff;
        end
    end

    // Decoded control registered so the port comes from a flop
    always_ff @(posedge tck) begin
        if (rstSync_ff) begin
            ctl <= '0;
        end else begin
            ctl <= dec;
        end
    end

    // Output wiring
    assign tdo = tdo_ff;
    assign tdoOeN = tdoOeN_ff;
    assign instruction = instr_ff;
    assign bsrUpdate = bsrShadow_ff;
    assign boundary_control_register = ctrlShadow_ff;
    assign runTest = runTest_ff;
    assign sysTestMode = modeSync_ff;
    assign sysTapReset = rstStSync_ff;

    // Consecutive TMS-high count, helper for the five-edge check
    logic [2:0] tmsRun_ff;
    always_ff @(posedge tck) begin
        if (rstSync_ff || !tms) begin
            tmsRun_ff <= 3'h0;
        end else if (tmsRun_ff != 3'h7) begin
            tmsRun_ff <= tmsRun_ff + 3'h1;
        end
    end

    // Five high mode levels in a row land in reset from anywhere
    tms_reset_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        tmsRun_ff >= 3'(bstap_pkg::TMS_RESET_EDGES) |-> state_ff == bstap_pkg::TEST_RESET)
        else $error("five TMS-high edges did not reach reset");
    // Reset state keeps the bypass opcode in force
    ir_reset_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::TEST_RESET |=> instr_ff == bstap_pkg::IR_RESET)
        else $error("instruction not all ones in reset");
    // Status pattern proves the instruction path is in place
    ir_capture_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::CAP_IR |=> irShift_ff == bstap_pkg::IR_CAPTURE)
        else $error("capture-IR pattern wrong");
    // Instruction stage moves one bit toward TDO per edge
    ir_shift_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::SHIFT_IR |=> irShift_ff == {$past(tdi), $past(irShift_ff[7:1])})
        else $error("instruction shift wrong");
    // Boundary stage shifts the same way, TDI into the top bit
    bsr_shift_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::SHIFT_DR && dec.selBsr |=> bsrShift_ff == {$past(tdi), $past(bsrShift_ff[39:1])})
        else $error("boundary shift wrong");
    // One-bit path loads zero on capture
    bypass_zero_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::CAP_DR && !dec.selBsr && !dec.selCtrl |=> bypass_ff == 1'b0)
        else $error("bypass did not capture zero");
    // Capture must leave the control stage untouched
    ctrl_capture_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::CAP_DR |=> $stable(ctrlShift_ff))
        else $error("control stage changed in capture");
    // Pause must not lose any scanned bit
    pause_hold_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::PAUSE_DR ##1 state_ff == bstap_pkg::PAUSE_DR |-> $stable(bsrShift_ff))
        else $error("boundary shift changed in pause");
    // Select states are left on the very next edge
    select_leave_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        (state_ff == bstap_pkg::SEL_DR || state_ff == bstap_pkg::SEL_IR) |=> state_ff != $past(state_ff))
        else $error("select state held");
    // Enable seen here was set on the fall inside this shift cycle; the next one may already be exit
    tdo_active_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::SHIFT_DR |-> !tdoOeN_ff)
        else $error("TDO not driven in shift-DR");
    // Same for instruction shifting
    tdo_ir_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::SHIFT_IR |-> !tdoOeN_ff)
        else $error("TDO not driven in shift-IR");
    // Released again once the scan leaves through exit1
    tdo_release_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::EXIT1_IR |=> tdoOeN_ff)
        else $error("TDO not released in exit1");
    // Shadows return to their reset values in the reset state
    ctrl_reset_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::TEST_RESET |=> ctrlShadow_ff == bstap_pkg::CTRL_RESET && bsrShadow_ff == '0)
        else $error("control or boundary shadow not reset");
    // Opcode becomes current on the fall inside update
    ir_update_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::UPD_IR |=> instr_ff == $past(irShift_ff))
        else $error("instruction not latched at update");
    // Boundary shadow takes the shift stage on the update fall
    bsr_update_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::UPD_DR && dec.selBsr |=> bsrShadow_ff == $past(bsrShift_ff))
        else $error("boundary shadow not updated");
    // Control-register operations confined to run-idle
    run_only_a: assert property (@(posedge tck) disable iff (rstSync_ff)
        runTest_ff |-> state_ff == bstap_pkg::RUN_IDLE)
        else $error("run strobe outside run-idle");

    // Main scenarios, each reached at least once
    ir_scan_c: cover property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::SHIFT_IR ##1 state_ff == bstap_pkg::EXIT1_IR ##1 state_ff == bstap_pkg::UPD_IR);
    dr_pause_c: cover property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::PAUSE_DR ##1 state_ff == bstap_pkg::EXIT2_DR ##1 state_ff == bstap_pkg::SHIFT_DR);
    bsr_update_c: cover property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::UPD_DR && dec.selBsr);
    ctrl_update_c: cover property (@(posedge tck) disable iff (rstSync_ff)
        state_ff == bstap_pkg::UPD_DR && dec.selCtrl);
    run_ctrl_c: cover property (@(posedge tck) disable iff (rstSync_ff) runTest_ff);
endmodule : bstap_core

//--- bstap_pkg.sv
// Shared constants and types for the boundary-scan port controller
//
// Overview of operation
// - Power-up starts in reset; normal function unaltered
// - TMS high five edges reaches reset state
// - Reset loads instruction with all ones
// - Boundary cells cleared while in reset
// - Boundary control resets to signature, no masking
// - Control-register operations run only in run-idle
// - Select states do nothing, leave next edge
// - Capture-DR loads selected register on exit edge; control register is left unchanged
// - Shift-DR drives TDO LSB from falling edge
// - Shift on each rising edge after entry
// - Exit1 returns TDO to high impedance
// - Re-entering shift from exit skips capture
// - Pause holds shift contents indefinitely
// - Update-DR loads shadow latches on falling edge
// - Capture-IR loads fixed pattern 10000001
// - Shift-IR drives TDO LSB from falling edge
// - Update-IR latches instruction on falling edge
// - Eight-bit opcode, bit 7 even parity
// - Unimplemented opcodes act as bypass
// - Registers are shift stage plus shadow latch
// - Instruction picks mode, operation, register, source
// - Sample on rising, change TDO on falling
// - Sixteen states stepped by sampled TMS
// - Bypass stage captures zero, no shadow
package bstap_pkg;
    // Register widths
    localparam int IR_W = 8;
    localparam int BSR_W = 40;
    localparam int CTRL_W = 11;
    localparam int TMS_RESET_EDGES = 5;
    // Reset and capture values
    localparam logic [7:0] IR_RESET = 8'hFF;
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [10:0] CTRL_RESET = 11'h002;
    localparam logic [39:0] BSR_RESET = 40'h00_0000_0000;
    // Implemented opcodes
    localparam logic [7:0] OP_EXTEST = 8'h00;
    localparam logic [7:0] OP_SAMPLE = 8'h82;
    localparam logic [7:0] OP_INTEST = 8'h03;
    localparam logic [7:0] OP_HIGHZ = 8'h06;
    // Control-register scan and run opcode; arbitrary even-parity value
    localparam logic [7:0] OP_RUN_CTRL = 8'h87;

    // Port controller states
    typedef enum logic [3:0] {
        TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } bstap_state_t;

    // Decoded instruction
    typedef struct packed {
        logic testMode;
        logic highZ;
        logic selBsr;
        logic selCtrl;
        logic capturePins;
    } bstap_ctl_t;
endpackage : bstap_pkg

//--- bstap_host_model.sv
// Behavioural scan-bus controller that drives the link side of the port
`timescale 1ns/1ns
module bstap_host_model (
    // Scan link toward the device
    output logic tck,
    output logic tms,
    output logic tdi,
    // Serial answer from the device
    input wire logic tdo,
    input wire logic tdoOeN
);
    // Link clock stands low between frames; pull-ups hold mode and data high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One link cycle: launch after the fall, sample the answer at the rise
    task automatic step(input logic m, input logic d, output logic o, output logic e);
        tms = m;
        tdi = d;
        #3 tck = 1'b1;
        // A released line reads as the inverse of its last level, so a stale bit cannot pass
        o = tdoOeN ? !tdo : tdo;
        e = tdoOeN;
        #3 tck = 1'b0;
    endtask : step

    // Hold one mode level for n cycles with data at its pulled-up level
    task automatic run(input logic m, input int n);
        logic o;
        logic e;
        repeat (n) step(m, 1'b1, o, e);
    endtask : run

    // Full scan from run-idle back to run-idle, optional pause after pauseAt bits
    task automatic scan(input bit ir, input logic [63:0] din, input int n, input int pauseAt,
                        output logic [63:0] dout, output logic oeHigh);
        logic o;
        logic e;
        dout = 64'h0000_0000_0000_0000;
        oeHigh = 1'b0;
        // Every scan starts and ends in run-idle, never straight from reset
        step(1'b1, 1'b1, o, e);
        if (ir) begin
            step(1'b1, 1'b1, o, e);
        end
        step(1'b0, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        for (int i = 0; i < n; i++) begin
            // Last bit leaves the shift state on its own edge
            step((i == n - 1) || (i == pauseAt - 1), din[i], o, e);
            dout[i] = o;
            oeHigh = oeHigh | e;
            if (i == pauseAt - 1) begin
                // Exit1, pause twice, exit2, back into shift
                step(1'b0, 1'b1, o, e);
                step(1'b0, 1'b1, o, e);
                step(1'b1, 1'b1, o, e);
                step(1'b0, 1'b1, o, e);
            end
        end
        step(1'b1, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
    endtask : scan
endmodule : bstap_host_model

//--- boundary_scan_tap_and_ir_tb_top.sv
// Self-checking bench for the boundary-scan port controller
`timescale 1ns/1ns
module boundary_scan_tap_and_ir_tb_top;
    logic clock;
    logic srst;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdoOeN;
    logic [39:0] pinSample;
    logic [39:0] bsrUpdate;
    logic [7:0] instruction;
    logic [10:0] ctrlShadow;
    bstap_pkg::bstap_ctl_t ctl;
    logic runTest;
    logic sysTestMode;
    logic sysTapReset;
    logic [63:0] dout;
    logic oeHigh;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] byOps [4] = '{8'h01, 8'h84, 8'h05, 8'h06};
    logic [7:0] modeOps [3] = '{8'h00, 8'h03, 8'h82};

    bstap_core u_bstap_core (.clock(clock), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOeN(tdoOeN), .pinSample(pinSample), .ctl(ctl), .instruction(instruction), .bsrUpdate(bsrUpdate),
        .boundary_control_register(ctrlShadow), .runTest(runTest), .sysTestMode(sysTestMode),
        .sysTapReset(sysTapReset));
    bstap_host_model u_bstap_host_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN));

    // System clock, 20 ns period
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // Instruction load; the captured status must come out while the opcode goes in
    task automatic loadIr(input logic [7:0] op);
        u_bstap_host_model.scan(1'b1, {56'h0, op}, 8, 0, dout, oeHigh);
        check(dout[7:0], 8'h81);
        check(oeHigh, 1'b0);
        check(tdoOeN, 1'b1);
        check(instruction, op);
    endtask : loadIr

    // Wait long enough for the two-flop system-side synchronisers
    task automatic sysWait();
        repeat (5) @(posedge clock);
    endtask : sysWait

    initial begin
        srst = 1'b1;
        pinSample = 40'h00_0000_0000;
        // Link clock must run during reset so the link side sees it
        fork
            repeat (12) @(posedge clock);
            u_bstap_host_model.run(1'b1, 8);
        join
        srst <= 1'b0;
        u_bstap_host_model.run(1'b1, 3);
        sysWait();
        check(instruction, 8'hFF);
        check(bsrUpdate, 40'h00_0000_0000);
        check(ctrlShadow, 11'h002);
        check(sysTestMode, 1'b0);
        check(sysTapReset, 1'b1);
        u_bstap_host_model.run(1'b0, 1);
        // Boundary sample with a paused scan in the middle
        loadIr(8'h82);
        @(posedge clock);
        pinSample <= 40'hA5_C3F0_1E69;
        @(posedge clock);
        u_bstap_host_model.run(1'b0, 3);
        u_bstap_host_model.scan(1'b0, {24'h0, 40'h3C_5A96_0FF0}, 40, 17, dout, oeHigh);
        check(dout[39:0], 40'hA5_C3F0_1E69);
        check(oeHigh, 1'b0);
        check(bsrUpdate, 40'h3C_5A96_0FF0);
        // Bad parity, unimplemented codes and the high-impedance code all give a one-bit path
        foreach (byOps[k]) begin
            loadIr(byOps[k]);
            check(ctl, byOps[k] == 8'h06 ? 5'h18 : 5'h00);
            u_bstap_host_model.scan(1'b0, 64'h0000_0000_0000_0001, 2, 0, dout, oeHigh);
            check(dout[1:0], 2'h2);
        end
        // Mode change seen on the system side
        foreach (modeOps[k]) begin
            loadIr(modeOps[k]);
            u_bstap_host_model.run(1'b0, 2);
            sysWait();
            check(sysTestMode, modeOps[k] != 8'h82);
            check(ctl, modeOps[k] == 8'h82 ? 5'h05 : 5'h15);
            check(sysTapReset, 1'b0);
        end
        // Control register scan; capture leaves the reset value in the shift stage
        loadIr(8'h87);
        u_bstap_host_model.scan(1'b0, 64'h0000_0000_0000_0155, 11, 0, dout, oeHigh);
        check(dout[10:0], 11'h002);
        check(ctrlShadow, 11'h155);
        u_bstap_host_model.run(1'b0, 2);
        check(runTest, 1'b1);
        u_bstap_host_model.run(1'b1, 1);
        u_bstap_host_model.run(1'b0, 2);
        check(runTest, 1'b0);
        // From shift-DR, five high mode cycles must reach reset
        u_bstap_host_model.run(1'b1, 5);
        sysWait();
        check(sysTapReset, 1'b1);
        check(instruction, 8'hFF);
        check(bsrUpdate, 40'h00_0000_0000);
        check(ctrlShadow, 11'h002);
        final_report();
    end
endmodule : boundary_scan_tap_and_ir_tb_top
